// ===== verilog/dbc_pkg.sv
// Constants, types and field layout for the dual-bridge chopper control.
// Assumes one 25 MHz clock and an APB master on the register side.
package dbc_pkg;

  localparam int unsigned CLK_NS = 40;
  localparam int unsigned T_SHORT_NS = 2000;
  localparam int unsigned T_PWM_NS = 5000;
  // Least times, rounded up to whole cycles
  localparam int unsigned SHORT_CYC = (T_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWM_CYC = (T_PWM_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [6:0] SHORT_WIN_OPEN = 7'(SHORT_CYC);
  localparam logic [6:0] SHORT_WIN_CLOSE = 7'(PWM_CYC);
  localparam logic [2:0] SHORT_RETRY_LAST = 3'h7;

  // APB register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [5:0] CTRL_RST = 6'h36;

  // Control byte fields
  localparam int unsigned CTRL_A_PHASE = 3;
  localparam int unsigned CTRL_B_PHASE = 0;
  localparam int unsigned CTRL_A_CUR = 4;
  localparam int unsigned CTRL_B_CUR = 1;

  // Status fields
  localparam int unsigned ST_SINK_FAULT_N = 7;
  localparam int unsigned ST_OVC_N = 6;
  localparam int unsigned ST_LOCK = 2;
  localparam int unsigned ST_DISABLED = 0;

  // Current codes, upper bit first
  localparam logic [1:0] CUR_NONE = 2'h3;
  localparam logic [1:0] CUR_HOLD = 2'h2;
  localparam logic [1:0] CUR_MID = 2'h1;
  localparam logic [1:0] CUR_FULL = 2'h0;

  typedef enum logic [2:0] {
    BR_OFF = 3'b000,
    BR_DECAY = 3'b001,
    BR_DRIVE = 3'b010,
    BR_FREE = 3'b011,
    BR_LOCK = 3'b100
  } dbc_state_e;

  // Gate drives of one bridge: source and sink of each half
  typedef struct packed {
    logic src1;
    logic sink1;
    logic src2;
    logic sink2;
  } dbc_gate_s;

  // Analog comparator inputs of one bridge
  typedef struct packed {
    logic src_ovl;
    logic short_trip;
    logic sense_trip;
  } dbc_sense_s;

endpackage

// ===== verilog/dbc_bridge_ctrl.sv
// Dual full-bridge chopper control with APB control/status registers.
// Assumes comparator and oscillator inputs are asynchronous to i_clk.
//
// Local design decisions: the address map and register access over APB.
module dbc_bridge_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Oscillator: high while ramping up
  input wire logic i_osc_rising,
  // Comparators, index 0 bridge A, 1 bridge B
  input wire dbc_pkg::dbc_sense_s [1:0] i_sense,
  // Bridge drives and analog selects
  output dbc_pkg::dbc_gate_s [1:0] o_gate,
  output logic [1:0] [1:0] o_thr_code,
  output logic [1:0] o_short_window,
  output logic o_bridge_a_first_output,
  output logic o_bridge_b_first_output,
  // Error status, active low
  output logic o_overcurrent_status_bit,
  output logic o_sink_fault_status_bit
);
  import dbc_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] raw;
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] s3_q;
  logic [6:0] in_q;
  logic osc_prev_q;
  logic [1:0] trig;
  dbc_sense_s [1:0] sense;

  assign raw = {i_sense[1], i_sense[0], i_osc_rising};

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
      s3_q <= 7'h00;
      in_q <= 7'h00;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts once stages two and three agree
      in_q <= (s2_q & s3_q) | (in_q & (s2_q ^ s3_q));
      osc_prev_q <= in_q[0];
    end
  end

  assign sense[0] = in_q[3:1];
  assign sense[1] = in_q[6:4];
  // A triggers at the peak, B at the valley
  assign trig[0] = osc_prev_q & ~in_q[0];
  assign trig[1] = ~osc_prev_q & in_q[0];

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q;
  logic xfer_q;
  logic short_flag_q;
  logic ovc_flag_q;
  logic [1:0] disabled_q;
  logic [1:0] lock;
  logic [1:0] short_ev;
  logic [1:0] normal_ev;
  logic [1:0] ovl_ev;
  logic setup;
  logic access;
  logic hit;
  logic [31:0] status;

  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign o_pready = access;
  assign hit = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS);

  always_comb
  begin
    status = 32'h0000_0000;
    status[ST_SINK_FAULT_N] = ~short_flag_q;
    status[ST_OVC_N] = ~ovc_flag_q;
    status[ST_LOCK +: 2] = lock;
    status[ST_DISABLED +: 2] = disabled_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_pslverr <= ~hit;
      if (i_paddr == ADDR_CTRL)
        o_prdata <= {26'h0000000, ctrl_q};
      else if (i_paddr == ADDR_STATUS)
        o_prdata <= status;
      else
        o_prdata <= 32'h0000_0000;
    end
  end

  // A completed control write stands for the end of a byte transfer
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      ctrl_q <= CTRL_RST;
      xfer_q <= 1'b0;
    end
    else
    begin
      xfer_q <= access & i_pwrite & (i_paddr == ADDR_CTRL);
      if (access & i_pwrite & (i_paddr == ADDR_CTRL))
        ctrl_q <= i_pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Shared error flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      short_flag_q <= 1'b0;
      ovc_flag_q <= 1'b0;
    end
    else
    begin
      // set wins; a normal trip or a transfer overwrites it
      if (|short_ev)
        short_flag_q <= 1'b1;
      else if ((|normal_ev) | xfer_q)
        short_flag_q <= 1'b0;
      // overload flag set wins over the transfer clear
      if (|ovl_ev)
        ovc_flag_q <= 1'b1;
      else if (xfer_q)
        ovc_flag_q <= 1'b0;
    end
  end

  assign o_overcurrent_status_bit = ~ovc_flag_q;
  assign o_sink_fault_status_bit = ~short_flag_q;

  // ----------------------------------------------------------------
  // Per-bridge chopper
  // ----------------------------------------------------------------
  logic [1:0] phase;
  logic [1:0] [1:0] code;

  assign phase = {ctrl_q[CTRL_B_PHASE], ctrl_q[CTRL_A_PHASE]};
  assign code[0] = ctrl_q[CTRL_A_CUR +: 2];
  assign code[1] = ctrl_q[CTRL_B_CUR +: 2];

  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bridge
      dbc_state_e state_q;
      dbc_state_e state_d;
      logic [6:0] cnt_q;
      logic [2:0] retry_q;
      logic phase_prev_q;
      logic off_code;
      logic in_win;
      logic past_win;

      assign off_code = (code[b] == CUR_NONE);
      assign in_win = (cnt_q >= SHORT_WIN_OPEN) && (cnt_q < SHORT_WIN_CLOSE);
      assign past_win = (cnt_q >= SHORT_WIN_CLOSE);
      assign short_ev[b] = (state_q == BR_DRIVE) && in_win && sense[b].short_trip;
      assign normal_ev[b] = (state_q == BR_DRIVE) && past_win && sense[b].sense_trip;
      // only a conducting bridge can overload its source
      assign ovl_ev[b] = sense[b].src_ovl &&
        ((state_q == BR_DRIVE) || (state_q == BR_FREE));
      assign lock[b] = (state_q == BR_LOCK);

      always_comb
      begin
        state_d = state_q;
        if (off_code || disabled_q[b] || ovl_ev[b])
          state_d = BR_OFF;
        // only a conducting pair needs fast decay
        else if ((phase[b] != phase_prev_q) &&
          ((state_q == BR_DRIVE) || (state_q == BR_FREE)))
          state_d = BR_DECAY;
        else
        begin
          unique case (state_q)
            BR_OFF: state_d = BR_DRIVE;
            BR_DECAY:
              if (trig[b])
                state_d = BR_DRIVE;
            BR_DRIVE:
              // eighth short in a row locks the sink off
              if (short_ev[b] && (retry_q == SHORT_RETRY_LAST))
                state_d = BR_LOCK;
              else if (short_ev[b] || normal_ev[b])
                state_d = BR_FREE;
            BR_FREE:
              if (trig[b])
                state_d = BR_DRIVE;
            BR_LOCK:
              if (xfer_q)
                state_d = BR_DRIVE;
            default: state_d = BR_OFF;
          endcase
        end
      end

      always_ff @(posedge i_clk)
      begin
        if (!i_rstn)
        begin
          state_q <= BR_OFF;
          phase_prev_q <= 1'b0;
        end
        else
        begin
          state_q <= state_d;
          phase_prev_q <= phase[b];
        end
      end

      // blanking counter restarts at each sink turn-on
      always_ff @(posedge i_clk)
      begin
        if (!i_rstn)
          cnt_q <= 7'h00;
        else if ((state_d == BR_DRIVE) && (state_q != BR_DRIVE))
          cnt_q <= 7'h00;
        else if ((state_q == BR_DRIVE) && !past_win)
          cnt_q <= cnt_q + 7'h01;
      end

      always_ff @(posedge i_clk)
      begin
        if (!i_rstn)
          retry_q <= 3'h0;
        else if (short_ev[b])
          retry_q <= retry_q + 3'h1;
        else if (normal_ev[b] || xfer_q || (state_q == BR_OFF))
          retry_q <= 3'h0;
      end

      // source overload disables until a transfer, set wins
      always_ff @(posedge i_clk)
      begin
        if (!i_rstn)
          disabled_q[b] <= 1'b0;
        else if (ovl_ev[b])
          disabled_q[b] <= 1'b1;
        else if (xfer_q)
          disabled_q[b] <= 1'b0;
      end

      // phase taken with the state picks the diagonal; source held, sink chops
      always_ff @(posedge i_clk)
      begin
        if (!i_rstn)
        begin
          o_gate[b] <= '0;
          o_thr_code[b] <= CUR_NONE;
          o_short_window[b] <= 1'b0;
        end
        else
        begin
          o_gate[b].src1 <= phase_prev_q && ((state_q == BR_DRIVE) || (state_q == BR_FREE));
          o_gate[b].sink2 <= phase_prev_q && (state_q == BR_DRIVE);
          o_gate[b].src2 <= !phase_prev_q && ((state_q == BR_DRIVE) || (state_q == BR_FREE));
          o_gate[b].sink1 <= !phase_prev_q && (state_q == BR_DRIVE);
          o_thr_code[b] <= code[b];
          o_short_window[b] <= (state_q == BR_DRIVE) && in_win;
        end
      end
    end
  endgenerate

  assign o_bridge_a_first_output = o_gate[0].src1;
  assign o_bridge_b_first_output = o_gate[1].src1;

endmodule // dbc_bridge_ctrl

// ===== dv/dbc_bridge_ctrl_props.sv
// Concurrent checks on the bridge control ports.
// Assumes it is bound into every dbc_bridge_ctrl instance.
module dbc_bridge_ctrl_props (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  // Oscillator and bridge outputs
  input wire logic i_osc_rising,
  input wire dbc_pkg::dbc_gate_s [1:0] o_gate,
  input wire logic [1:0] [1:0] o_thr_code,
  input wire logic [1:0] o_short_window,
  input wire logic o_bridge_a_first_output,
  input wire logic o_bridge_b_first_output,
  input wire logic o_overcurrent_status_bit,
  input wire logic o_sink_fault_status_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbc_pkg::*;

  logic osc_q;
  logic wr_ctrl;
  logic [5:0] fall_age_q;
  logic [5:0] rise_age_q;
  logic [7:0] on_a_q;
  logic [1:0] ph_q;

  assign wr_ctrl = i_psel && i_penable && i_pwrite && i_paddr == ADDR_CTRL;

  // Cycles since each oscillator edge and since bridge A sink turned on
  always_ff @(posedge i_clk)
  begin
    osc_q <= i_osc_rising;
    fall_age_q <= (osc_q && !i_osc_rising) ? 6'h0 : fall_age_q + {5'h0, fall_age_q != 6'h3f};
    rise_age_q <= (!osc_q && i_osc_rising) ? 6'h0 : rise_age_q + {5'h0, rise_age_q != 6'h3f};
    on_a_q <= (o_gate[0].sink1 || o_gate[0].sink2) ? on_a_q + {7'h0, on_a_q != 8'hff} : 8'h0;
    // Phase bits as last written, index 0 bridge A
    if (wr_ctrl)
      ph_q <= {i_pwdata[CTRL_B_PHASE], i_pwdata[CTRL_A_PHASE]};
    if (!i_rstn)
    begin
      fall_age_q <= 6'h3f;
      rise_age_q <= 6'h3f;
      ph_q <= 2'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_first_out;
    o_bridge_a_first_output == o_gate[0].src1 && o_bridge_b_first_output == o_gate[1].src1 &&
      (!o_bridge_a_first_output || ph_q[0] || $past(ph_q[0]) || $past(ph_q[0], 2)) &&
      (!o_bridge_b_first_output || ph_q[1] || $past(ph_q[1]) || $past(ph_q[1], 2));
  endproperty
  a_first_out: assert property (p_first_out) else $error("first output wrong");
  property p_pair;
    o_gate[0] inside {4'h9, 4'h8, 4'h6, 4'h2, 4'h0} && o_gate[1] inside {4'h9, 4'h8, 4'h6, 4'h2, 4'h0};
  endproperty
  a_pair: assert property (p_pair) else $error("gate pair illegal");
  property p_swap;
    $fell(o_gate[0].src1) || $fell(o_gate[0].src2) |-> o_gate[0] == 4'h0;
  endproperty
  a_swap: assert property (p_swap) else $error("source dropped without all off");
  property p_off;
    (o_thr_code[0] == CUR_NONE) [*3] |-> o_gate[0] == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("bridge on with no current");
  property p_blank;
    $fell(o_gate[0].sink1 || o_gate[0].sink2) && (o_gate[0].src1 || o_gate[0].src2) |-> on_a_q > 8'h2d;
  endproperty
  a_blank: assert property (p_blank) else $error("sink cut inside blanking");
  property p_retrig_a;
    $rose(o_gate[0].sink1 || o_gate[0].sink2) && $past(o_gate[0].src1 || o_gate[0].src2) |-> fall_age_q < 6'hc;
  endproperty
  a_retrig_a: assert property (p_retrig_a) else $error("bridge A on off its trigger");
  property p_retrig_b;
    $rose(o_gate[1].sink1 || o_gate[1].sink2) && $past(o_gate[1].src1 || o_gate[1].src2) |-> rise_age_q < 6'hc;
  endproperty
  a_retrig_b: assert property (p_retrig_b) else $error("bridge B on off its trigger");
  property p_short_flag;
    $fell(o_sink_fault_status_bit) |-> |(o_short_window | $past(o_short_window));
  endproperty
  a_short_flag: assert property (p_short_flag) else $error("short flag outside window");
  property p_ovc_off;
    $fell(o_overcurrent_status_bit) |-> ##[1:2]
      (($past(o_gate[0]) != 4'h0 && o_gate[0] == 4'h0) ||
      ($past(o_gate[1]) != 4'h0 && o_gate[1] == 4'h0));
  endproperty
  a_ovc_off: assert property (p_ovc_off) else $error("overload left bridge on");
  property p_ovc_hold;
    !o_overcurrent_status_bit && !wr_ctrl && !$past(wr_ctrl) && !$past(wr_ctrl, 2) |=> !o_overcurrent_status_bit;
  endproperty
  a_ovc_hold: assert property (p_ovc_hold) else $error("overload flag cleared early");
endmodule // dbc_bridge_ctrl_props

bind dbc_bridge_ctrl dbc_bridge_ctrl_props i_dbc_bridge_ctrl_props (.i_clk, .i_rstn, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_osc_rising, .o_gate, .o_thr_code,
  .o_short_window,
  .o_bridge_a_first_output, .o_bridge_b_first_output, .o_overcurrent_status_bit,
  .o_sink_fault_status_bit);

// ===== dv/dbc_stage_model.sv
// Power stage stand-in: oscillator and comparator levels for both bridges.
// Assumes bench fault codes: 0 none, 1 short to supply, 2 short to ground.
module dbc_stage_model (
  // Clock and bench controls
  input wire logic i_clk,
  input wire logic i_osc_run,
  input wire logic [1:0] [1:0] i_fault,
  // Bridge side
  input wire dbc_pkg::dbc_gate_s [1:0] i_gate,
  output logic o_osc,
  output dbc_pkg::dbc_sense_s [1:0] o_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbc_pkg::*;

  logic osc_q = 1'b0;
  logic [6:0] half_q = 7'h0;
  logic [1:0] [7:0] on_q = '0;

  assign o_osc = osc_q;

  // push-pull clock on the oscillator node, held while stopped
  always @(posedge i_clk)
  begin
    if (i_osc_run)
      half_q <= (half_q == 7'h63) ? 7'h0 : half_q + 7'h1;
    if (i_osc_run && half_q == 7'h63)
      osc_q <= ~osc_q;
    for (int b = 0; b < 2; b++)
      on_q[b] <= (i_gate[b].sink1 || i_gate[b].sink2) ? on_q[b] + {7'h0, on_q[b] != 8'hff} : 8'h0;
  end

  // Sink current ramps while on; supply short trips early, ground short at once
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      o_sense[b].sense_trip = on_q[b] > 8'h96;
      o_sense[b].short_trip = i_fault[b] == 2'h1 && on_q[b] > 8'h3c;
      o_sense[b].src_ovl = i_fault[b] == 2'h2 && (i_gate[b].src1 || i_gate[b].src2);
    end
  end
endmodule // dbc_stage_model

// ===== dv/tb.sv
// Self-checking bench for the dual-bridge chopper control.
// Assumes the stage model stands in for comparators and oscillator.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dbc_pkg::*;

  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic osc_run = 1'b1;
  logic [1:0] [1:0] fault = '0;
  logic pready, pslverr, osc, a_first, b_first, ovc_n, sink_n;
  logic [31:0] prdata;
  logic [1:0] [1:0] thr;
  dbc_gate_s [1:0] gate;
  dbc_sense_s [1:0] sense;
  int bad_count = 0;
  int comparisons = 0;

  always #20 i_clk = ~i_clk;

  dbc_bridge_ctrl i_dbc_bridge_ctrl (.i_clk, .i_rstn, .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_osc_rising(osc), .i_sense(sense),
    .o_gate(gate), .o_thr_code(thr), .o_short_window(), .o_bridge_a_first_output(a_first),
    .o_bridge_b_first_output(b_first), .o_overcurrent_status_bit(ovc_n),
    .o_sink_fault_status_bit(sink_n));
  dbc_stage_model i_dbc_stage_model (.i_clk, .i_osc_run(osc_run), .i_fault(fault),
    .i_gate(gate), .o_osc(osc), .o_sense(sense));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do
      @(posedge i_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [5:0] c);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {26'h0, c}, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, 32'h36, 1'b0);
    wr(8'h08, 6'h0);
    wr(ADDR_STATUS, 6'h0);
    rd(8'h08, 32'h0, 1'b1);
    rd(ADDR_STATUS, 32'hc0, 1'b0);
  endtask

  task automatic t_codes;
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CTRL, 6'h36);
      wr(ADDR_CTRL, {c[1:0], 1'b1, c[1:0], 1'b0});
      cyc(8);
      chk(32'(thr[0]), 32'(c));
      chk(32'(thr[1]), 32'(c));
      chk(32'(gate[0]), (c == 3) ? 32'h0 : 32'h9);
      chk(32'(gate[1]), (c == 3) ? 32'h0 : 32'h6);
      chk(32'(a_first), 32'(c != 3));
      chk(32'(b_first), 32'h0);
    end
  endtask

  task automatic t_phase;
    wr(ADDR_CTRL, 6'h0e);
    cyc(300);
    wr(ADDR_CTRL, 6'h06);
    cyc(3);
    chk(32'(gate[0]), 32'h0);
    cyc(250);
    chk(32'(a_first), 32'h0);
    chk(32'(gate[0].src2), 32'h1);
  endtask

  task automatic t_stop;
    osc_run <= 1'b0;
    cyc(400);
    chk(32'(gate[0].sink1), 32'h0);
    osc_run <= 1'b1;
    for (int i = 0; i < 300 && gate[0].sink1 !== 1'b1; i++) @(posedge i_clk);
    chk(32'(gate[0].sink1), 32'h1);
  endtask

  task automatic t_short;
    fault[0] <= 2'h1;
    for (int i = 0; i < 400 && sink_n !== 1'b0; i++) @(posedge i_clk);
    chk(32'(sink_n), 32'h0);
    chk(32'(ovc_n), 32'h1);
    cyc(2000);
    chk(32'(gate[0]), 32'h0);
    rd(ADDR_STATUS, 32'h44, 1'b0);
    // host holds the bridge off for 1 ms after a short
    wr(ADDR_CTRL, 6'h36);
    cyc(25000);
    fault[0] <= 2'h0;
    rd(ADDR_STATUS, 32'hc0, 1'b0);
  endtask

  task automatic t_ovl;
    wr(ADDR_CTRL, 6'h30);
    fault[1] <= 2'h2;
    for (int i = 0; i < 300 && ovc_n !== 1'b0; i++) @(posedge i_clk);
    chk(32'(ovc_n), 32'h0);
    cyc(4);
    chk(32'(gate[1]), 32'h0);
    fault[1] <= 2'h0;
    cyc(50);
    rd(ADDR_STATUS, 32'h82, 1'b0);
    wr(ADDR_CTRL, 6'h30);
    cyc(5);
    chk(32'(ovc_n), 32'h1);
    chk(32'(gate[1]), 32'h6);
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_regs;
    t_codes;
    t_phase;
    t_stop;
    t_short;
    t_ovl;
    give_verdict;
  end

  initial
  begin
    #2400000;
    bad_count++;
    give_verdict;
  end
endmodule // tb
